// *** shared/dsc_regs.svh ***
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
// Clock rate in kHz.
`define DSC_CLK_KHZ 100000
// Slow blink period in milliseconds.
`define DSC_SLOW_PERIOD_MS 2000
// Slow blink lit share in percent.
`define DSC_SLOW_LIT_PCT 20
// Steady blink lit share in percent.
`define DSC_STEADY_LIT_PCT 50
// Steady blink period in milliseconds.
`define DSC_STEADY_PERIOD_MS 1000
// Stagger delay per slot step in milliseconds.
`define DSC_STAGGER_MS 12000
// Derived cycle counts.
`define DSC_SLOW_PERIOD_CYC (`DSC_SLOW_PERIOD_MS * (`DSC_CLK_KHZ))
`define DSC_SLOW_LIT_CYC (`DSC_SLOW_PERIOD_CYC / 100 * `DSC_SLOW_LIT_PCT)
`define DSC_STEADY_PERIOD_CYC (`DSC_STEADY_PERIOD_MS * (`DSC_CLK_KHZ))
`define DSC_STEADY_LIT_CYC (`DSC_STEADY_PERIOD_CYC / 100 * `DSC_STEADY_LIT_PCT)
`define DSC_STAGGER_CYC (`DSC_STAGGER_MS * (`DSC_CLK_KHZ))
// Slot-ID field: low three bits select the stagger step.
`define DSC_SLOT_W 7
`define DSC_STAGGER_BITS 3
// Number of loop ports.
`define DSC_PORTS 2
`endif

// *** shared/dsc_pkg.sv ***
package dsc_pkg;
  // Motor start decisions from the two option inputs.
  typedef enum logic [1:0] {
    DSC_START_NOW = 2'h0,
    DSC_START_CMD = 2'h1,
    DSC_START_DLY = 2'h2,
    DSC_START_NEVER = 2'h3
  } dsc_start_t;
  // Spindle condition reported by the motor controller.
  typedef enum logic [1:0] {
    DSC_SPIN_STOP = 2'h0,
    DSC_SPIN_RAMP = 2'h1,
    DSC_SPIN_SPEED = 2'h2
  } dsc_spin_t;
  // Per-port link events and failures.
  typedef struct packed {
    logic lpb_seen;
    logic lpe_seen;
    logic wrap_fail;
    logic rx_clk_lost;
    logic tx_clk_lost;
    logic if_hw_err;
  } dsc_port_ev_t;
endpackage

// *** hw/dsc_sync.sv ***
`timescale 1ns/1ns
`include "dsc_regs.svh"
// ----------------------------------------
// Two-stage synchroniser for pin levels
// ----------------------------------------
module dsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r; // First stage, read only by the second.
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_nxt;
  // Next values simply shift through.
  always_comb begin
    s1_nxt = d;
    q_nxt = s1_r;
  end
  // Reset to the idle level of the pins.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= s1_nxt;
      q <= q_nxt;
    end
  end
endmodule

// *** hw/dsc_bypass.sv ***
`timescale 1ns/1ns
`include "dsc_regs.svh"
// ----------------------------------------
// Per-port bypass request holder
// ----------------------------------------
module dsc_bypass (
  input wire logic clk,
  input wire logic resetn,
  input dsc_pkg::dsc_port_ev_t ev,
  input wire logic internal_fail,
  input wire logic self_test_done,
  output logic bypass_r
);
  logic hw_fail; // Any link failure that forces bypass.
  logic bypass_nxt;
  // Failures combine into one term.
  always_comb begin
    hw_fail = ev.wrap_fail | ev.rx_clk_lost | ev.tx_clk_lost | ev.if_hw_err;
    bypass_nxt = bypass_r;
    if (hw_fail || internal_fail || ev.lpb_seen) begin
      // Set wins over a release seen in the same cycle.
      bypass_nxt = 1'b1;
    end else if (ev.lpe_seen && self_test_done) begin
      bypass_nxt = 1'b0;
    end
  end
  // Start bypassed until self-test lets the loop enable us; safe for the loop.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bypass_r <= 1'b1;
    end else begin
      bypass_r <= bypass_nxt;
    end
  end
endmodule

// *** hw/dsc_top.sv ***
`timescale 1ns/1ns
`include "dsc_regs.svh"
// How it works
// - Fault lamp on: both ports, internal, command
// - Lamp outputs sink current, active low
// - Stopped idle: 20 percent of 2 seconds
// - Stopped busy: lamp steadily lit
// - At speed idle: lamp steadily lit
// - At speed busy: lamp dark
// - Ramping: lamp blinks half on half off
// - Format: lamp toggles each cylinder change
// - Bypass requests active low per port
// - Bypass indicator low while request active
// - Bypass on failure or bypass primitive
// - Receiver stays on while port bypassed
// - Enable primitive releases after clean self-test
// - Wrap, clock losses, interface error bypass
// - Both start inputs low: spin immediately
// - Start_2 high only: wait for command
// - Start_1 high only: 12 s times slot mod 8
// - Both start inputs high: never spin
// - Option pins pulled high inside device
// - Slot ID is seven backplane lines
module dsc_top #(
  parameter int SLOW_PERIOD_CYC = `DSC_SLOW_PERIOD_CYC,
  parameter int SLOW_LIT_CYC = `DSC_SLOW_LIT_CYC,
  parameter int STEADY_PERIOD_CYC = `DSC_STEADY_PERIOD_CYC,
  parameter int STEADY_LIT_CYC = `DSC_STEADY_LIT_CYC,
  parameter int STAGGER_CYC = `DSC_STAGGER_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start_1_pin,
  input wire logic start_2_pin,
  input wire logic [`DSC_SLOT_W-1:0] slot_id_pin,
  input wire logic port_a_fail,
  input wire logic port_b_fail,
  input wire logic internal_fail,
  input wire logic fault_cmd,
  input dsc_pkg::dsc_port_ev_t port_a_ev,
  input dsc_pkg::dsc_port_ev_t port_b_ev,
  input wire logic self_test_done,
  input dsc_pkg::dsc_spin_t spin_state,
  input wire logic cmd_active,
  input wire logic format_active,
  input wire logic cyl_change,
  input wire logic host_start_cmd,
  output logic fault_indicator_n,
  output logic fault_indicator_oe,
  output logic activity_indicator_n,
  output logic activity_indicator_oe,
  output logic bypass_a_n,
  output logic bypass_b_n,
  output logic bypass_led_a_n,
  output logic bypass_led_b_n,
  output logic rx_enable_a,
  output logic rx_enable_b,
  output logic spin_up_req
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  // Option pins idle high, as their internal pull-ups make them.
  logic [1:0] start_s; // Bit 0 is start_1, bit 1 is start_2.
  logic [`DSC_SLOT_W-1:0] slot_s; // Synchronised slot ID.
  dsc_sync #(.W(2), .INIT(2'h3)) u_sync_start (
    .clk(clk),
    .resetn(resetn),
    .d({start_2_pin, start_1_pin}),
    .q(start_s)
  );
  // Slot lines are driven by the backplane; no pull-up is assumed.
  dsc_sync #(.W(`DSC_SLOT_W), .INIT(7'h00)) u_sync_slot (
    .clk(clk),
    .resetn(resetn),
    .d(slot_id_pin),
    .q(slot_s)
  );

  // ----------------------------------------
  // Bypass control per port
  // ----------------------------------------
  logic byp_a; // Port A bypassed.
  logic byp_b; // Port B bypassed.
  dsc_bypass u_byp_a (
    .clk(clk),
    .resetn(resetn),
    .ev(port_a_ev),
    .internal_fail(internal_fail),
    .self_test_done(self_test_done),
    .bypass_r(byp_a)
  );
  dsc_bypass u_byp_b (
    .clk(clk),
    .resetn(resetn),
    .ev(port_b_ev),
    .internal_fail(internal_fail),
    .self_test_done(self_test_done),
    .bypass_r(byp_b)
  );

  // ----------------------------------------
  // Motor start decision
  // ----------------------------------------
  // The option code is sampled once, shortly after reset, so a later
  // pin glitch cannot change the spin-up policy.
  typedef enum logic [1:0] {
    DSC_M_SAMPLE = 2'h0,
    DSC_M_WAIT = 2'h1,
    DSC_M_RUN = 2'h2,
    DSC_M_HOLD = 2'h3
  } dsc_mstate_t;
  dsc_mstate_t m_r, m_nxt; // Motor start state.
  logic [1:0] settle_r, settle_nxt; // Lets the synchronisers fill.
  dsc_pkg::dsc_start_t mode_r, mode_nxt; // Chosen start policy.
  // Seven 12 s steps at 100 MHz overflow 32 bits, so the delay path is 34 bits wide.
  logic [33:0] dly_r, dly_nxt; // Remaining stagger delay in cycles.
  logic spin_r, spin_nxt; // Spin-up request.
  logic [33:0] stagger_total; // Delay for this slot.
  // Compute next motor-start state.
  always_comb begin
    stagger_total = 34'(STAGGER_CYC) *
      34'(slot_s[`DSC_STAGGER_BITS-1:0]);
    m_nxt = m_r;
    settle_nxt = settle_r;
    mode_nxt = mode_r;
    dly_nxt = dly_r;
    spin_nxt = spin_r;
    unique case (m_r)
      DSC_M_SAMPLE: begin
        if (settle_r != 2'h3) begin
          settle_nxt = settle_r + 2'h1;
        end else begin
          mode_nxt = dsc_pkg::dsc_start_t'({start_s[0], start_s[1]});
          dly_nxt = stagger_total;
          m_nxt = DSC_M_WAIT;
        end
      end
      DSC_M_WAIT: begin
        unique case (mode_r)
          dsc_pkg::DSC_START_NOW: begin
            m_nxt = DSC_M_RUN;
          end
          dsc_pkg::DSC_START_CMD: begin
            if (host_start_cmd) begin
              m_nxt = DSC_M_RUN;
            end
          end
          dsc_pkg::DSC_START_DLY: begin
            if (dly_r == 34'h0) begin
              m_nxt = DSC_M_RUN;
            end else begin
              dly_nxt = dly_r - 34'h1;
            end
          end
          dsc_pkg::DSC_START_NEVER: begin
            m_nxt = DSC_M_HOLD;
          end
        endcase
      end
      DSC_M_RUN: begin
        spin_nxt = 1'b1;
      end
      DSC_M_HOLD: begin
        spin_nxt = 1'b0;
      end
    endcase
  end
  // Register motor-start state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_r <= DSC_M_SAMPLE;
      settle_r <= 2'h0;
      mode_r <= dsc_pkg::DSC_START_NEVER;
      dly_r <= 34'h0;
      spin_r <= 1'b0;
    end else begin
      m_r <= m_nxt;
      settle_r <= settle_nxt;
      mode_r <= mode_nxt;
      dly_r <= dly_nxt;
      spin_r <= spin_nxt;
    end
  end

  // ----------------------------------------
  // Activity lamp pattern
  // ----------------------------------------
  logic [31:0] slow_cnt_r, slow_cnt_nxt; // Slow blink phase.
  logic [31:0] fast_cnt_r, fast_cnt_nxt; // Steady blink phase.
  logic fmt_lit_r, fmt_lit_nxt; // Format toggle state.
  logic act_lit; // Lamp lit this cycle.
  // Free-running blink counters and format toggle.
  always_comb begin
    slow_cnt_nxt = (slow_cnt_r == 32'(SLOW_PERIOD_CYC - 1)) ? 32'h0 :
      slow_cnt_r + 32'h1;
    fast_cnt_nxt = (fast_cnt_r == 32'(STEADY_PERIOD_CYC - 1)) ? 32'h0 :
      fast_cnt_r + 32'h1;
    fmt_lit_nxt = fmt_lit_r;
    if (format_active && cyl_change) begin
      fmt_lit_nxt = ~fmt_lit_r;
    end
  end
  // Choose the lamp state; format overrides the spindle table.
  always_comb begin
    act_lit = 1'b0;
    if (format_active) begin
      act_lit = fmt_lit_r;
    end else begin
      unique case (spin_state)
        dsc_pkg::DSC_SPIN_STOP: begin
          if (cmd_active) begin
            act_lit = 1'b1;
          end else begin
            act_lit = slow_cnt_r < 32'(SLOW_LIT_CYC);
          end
        end
        dsc_pkg::DSC_SPIN_SPEED: begin
          act_lit = !cmd_active;
        end
        dsc_pkg::DSC_SPIN_RAMP: begin
          act_lit = fast_cnt_r < 32'(STEADY_LIT_CYC);
        end
        default: begin
          act_lit = 1'b0;
        end
      endcase
    end
  end
  // Register blink state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slow_cnt_r <= 32'h0;
      fast_cnt_r <= 32'h0;
      fmt_lit_r <= 1'b0;
    end else begin
      slow_cnt_r <= slow_cnt_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      fmt_lit_r <= fmt_lit_nxt;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic fault_nxt; // Fault lamp lit.
  logic act_nxt; // Activity lamp lit.
  // Lamp pins sink only: the enable is on exactly while lit, value is low.
  always_comb begin
    fault_nxt = (port_a_fail && port_b_fail) || internal_fail || fault_cmd;
    act_nxt = act_lit;
  end
  // All outputs come straight from flip-flops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_indicator_n <= 1'b0;
      fault_indicator_oe <= 1'b0;
      activity_indicator_n <= 1'b0;
      activity_indicator_oe <= 1'b0;
      bypass_a_n <= 1'b0;
      bypass_b_n <= 1'b0;
      bypass_led_a_n <= 1'b0;
      bypass_led_b_n <= 1'b0;
      rx_enable_a <= 1'b1;
      rx_enable_b <= 1'b1;
      spin_up_req <= 1'b0;
    end else begin
      fault_indicator_n <= 1'b0;
      fault_indicator_oe <= fault_nxt;
      activity_indicator_n <= 1'b0;
      activity_indicator_oe <= act_nxt;
      bypass_a_n <= ~byp_a;
      bypass_b_n <= ~byp_b;
      bypass_led_a_n <= ~byp_a;
      bypass_led_b_n <= ~byp_b;
      rx_enable_a <= 1'b1;
      rx_enable_b <= 1'b1;
      spin_up_req <= spin_r;
    end
  end
endmodule

// *** sim/dsc_top_checker.sv ***
`timescale 1ns/1ns
`include "dsc_regs.svh"
// ----------------------------------------
// Port checker for the sideband block
// ----------------------------------------
module dsc_top_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic port_a_fail,
  input wire logic port_b_fail,
  input wire logic internal_fail,
  input wire logic fault_cmd,
  input dsc_pkg::dsc_port_ev_t port_a_ev,
  input dsc_pkg::dsc_port_ev_t port_b_ev,
  input wire logic self_test_done,
  input dsc_pkg::dsc_spin_t spin_state,
  input wire logic cmd_active,
  input wire logic format_active,
  input logic fault_indicator_n,
  input logic fault_indicator_oe,
  input logic activity_indicator_n,
  input logic activity_indicator_oe,
  input logic bypass_a_n,
  input logic bypass_b_n,
  input logic bypass_led_a_n,
  input logic bypass_led_b_n,
  input logic rx_enable_a,
  input logic rx_enable_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // At speed without format; three samples cover either lamp latency.
  wire fast = (spin_state == dsc_pkg::DSC_SPIN_SPEED) && !format_active;
  // Any of the four link failures on port A.
  wire fail_a = |port_a_ev[3:0];
  fault_on_a: assert property ((fault_cmd || internal_fail || (port_a_fail && port_b_fail))
    |=> fault_indicator_oe) else $error("fault lamp not lit");
  lamp_sink_a: assert property (!fault_indicator_n && !activity_indicator_n)
    else $error("lamp pin value not low");
  idle_lit_a: assert property ((fast && !cmd_active)[*3] |-> activity_indicator_oe)
    else $error("idle lamp dark");
  busy_dark_a: assert property ((fast && cmd_active)[*3] |-> !activity_indicator_oe)
    else $error("busy lamp lit");
  led_follow_a: assert property (bypass_led_a_n == bypass_a_n && bypass_led_b_n == bypass_b_n)
    else $error("bypass led differs");
  rx_kept_a: assert property (rx_enable_a && rx_enable_b)
    else $error("receiver off");
  lpb_bypass_a: assert property ((port_a_ev.lpb_seen || internal_fail) |-> ##2 !bypass_a_n)
    else $error("port A not bypassed");
  lpb_port_b_a: assert property (port_b_ev.lpb_seen |-> ##2 !bypass_b_n)
    else $error("port B not bypassed");
  fail_bypass_a: assert property (fail_a |-> ##2 !bypass_a_n)
    else $error("failure did not bypass");
  release_a: assert property ($rose(bypass_a_n) |-> $past(self_test_done, 2)
    && $past(port_a_ev.lpe_seen, 2)) else $error("bad release");
  // Main scenarios reached.
  cover property ($rose(bypass_a_n));
  cover property ($rose(fault_indicator_oe));
  cover property (spin_state == dsc_pkg::DSC_SPIN_RAMP && activity_indicator_oe);
endmodule
bind dsc_top dsc_top_checker i_dsc_top_checker (.clk(clk), .resetn(resetn),
  .port_a_fail(port_a_fail), .port_b_fail(port_b_fail), .internal_fail(internal_fail),
  .fault_cmd(fault_cmd), .port_a_ev(port_a_ev), .port_b_ev(port_b_ev),
  .self_test_done(self_test_done), .spin_state(spin_state), .cmd_active(cmd_active),
  .format_active(format_active), .fault_indicator_n(fault_indicator_n),
  .fault_indicator_oe(fault_indicator_oe), .activity_indicator_n(activity_indicator_n),
  .activity_indicator_oe(activity_indicator_oe), .bypass_a_n(bypass_a_n),
  .bypass_b_n(bypass_b_n), .bypass_led_a_n(bypass_led_a_n),
  .bypass_led_b_n(bypass_led_b_n), .rx_enable_a(rx_enable_a), .rx_enable_b(rx_enable_b));

// *** sim/dsc_backplane.sv ***
`timescale 1ns/1ns
`include "dsc_regs.svh"
// ----------------------------------------
// Backplane straps and loop bypass circuits
// ----------------------------------------
module dsc_backplane (
  input wire logic gnd_1,
  input wire logic gnd_2,
  input wire logic [`DSC_SLOT_W-1:0] slot,
  input wire logic bypass_a_n,
  input wire logic bypass_b_n,
  output logic start_1_pin,
  output logic start_2_pin,
  output logic [`DSC_SLOT_W-1:0] slot_id_pin,
  output logic loop_skip_a,
  output logic loop_skip_b
);
  // An open strap reads high through the internal pull-up.
  assign start_1_pin = gnd_1 ? 1'h0 : 1'h1;
  assign start_2_pin = gnd_2 ? 1'h0 : 1'h1;
  assign slot_id_pin = slot;
  // A low request makes the circuit route the loop around the drive.
  assign loop_skip_a = ~bypass_a_n;
  assign loop_skip_b = ~bypass_b_n;
endmodule

// *** sim/tb_dsc_top.sv ***
`timescale 1ns/1ns
`include "dsc_regs.svh"
module tb_dsc_top;
  logic clk = 1'h0, resetn = 1'h0, g1 = 1'h0, g2 = 1'h0, pa_f = 1'h0, pb_f = 1'h0;
  logic int_f = 1'h0, f_cmd = 1'h0, st_done = 1'h0, cmd = 1'h0, fmt = 1'h0;
  logic cyl = 1'h0, hst = 1'h0, s1, s2, f_n, f_oe, a_n, a_oe, b_a, b_b, prev, sp;
  logic [6:0] slot = 7'h03;
  logic [6:0] sid;
  dsc_pkg::dsc_port_ev_t ev_a = '0, ev_b = '0;
  dsc_pkg::dsc_spin_t spin = dsc_pkg::DSC_SPIN_STOP;
  logic [9:0] notes[$];
  logic [9:0] n;
  logic [31:0] seed = 32'h9B1598E7;
  logic [4:0] obs;
  int miscompares = 0, cmp_count = 0, k, j, lit;
  event smp;
  // Outputs gathered for comparison: fault, activity, bypass A, bypass B, spin.
  assign obs = {f_oe, a_oe, b_a, b_b, sp};
  dsc_top #(.SLOW_PERIOD_CYC(100), .SLOW_LIT_CYC(20), .STEADY_PERIOD_CYC(10),
    .STEADY_LIT_CYC(5), .STAGGER_CYC(50)) i_dsc_top (.clk(clk), .resetn(resetn),
    .start_1_pin(s1), .start_2_pin(s2), .slot_id_pin(sid), .port_a_fail(pa_f),
    .port_b_fail(pb_f), .internal_fail(int_f), .fault_cmd(f_cmd), .port_a_ev(ev_a),
    .port_b_ev(ev_b), .self_test_done(st_done), .spin_state(spin), .cmd_active(cmd),
    .format_active(fmt), .cyl_change(cyl), .host_start_cmd(hst), .fault_indicator_n(f_n),
    .fault_indicator_oe(f_oe), .activity_indicator_n(a_n), .activity_indicator_oe(a_oe),
    .bypass_a_n(b_a), .bypass_b_n(b_b), .bypass_led_a_n(), .bypass_led_b_n(),
    .rx_enable_a(), .rx_enable_b(), .spin_up_req(sp));
  dsc_backplane i_dsc_backplane (.gnd_1(g1), .gnd_2(g2), .slot(slot), .bypass_a_n(b_a),
    .bypass_b_n(b_b), .start_1_pin(s1), .start_2_pin(s2), .slot_id_pin(sid),
    .loop_skip_a(), .loop_skip_b());
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // A note holds the mask above the expected value; the monitor consumes it.
  task automatic want(input logic [4:0] m, input logic [4:0] e);
    notes.push_back({m, e});
    ->smp;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Lit cycles over a window; a whole period holds exactly the lit share.
  task automatic count(input int c);
    lit = 0;
    repeat (c) begin
      @(posedge clk);
      #1 lit += a_oe;
    end
    cyc(1);
  endtask
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic pulse_a(input logic [5:0] v);
    ev_a = dsc_pkg::dsc_port_ev_t'(v);
    ev_b = ev_a;
    cyc(1);
    ev_a = '0;
    ev_b = '0;
    cyc(3);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  // Monitor: oldest note against the masked outputs; drains notes posted in one step.
  initial begin
    forever begin
      @smp;
      while (notes.size() > 0) begin
        n = notes.pop_front();
        check(obs & n[9:5], n[4:0]);
        check({3'h0, f_n, a_n}, 5'h00);
      end
    end
  end
  // Watchdog sized well above the expected run of about 1100 cycles.
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    // Mode = {start_1, start_2}; the option code is taken once after reset.
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      slot = {seed[3:0], 3'h3};
      resetn = 1'h0;
      g1 = !k[1];
      g2 = !k[0];
      cyc(12);
      resetn = 1'h1;
      cyc(140);
      want(5'h01, {4'h0, 1'(k == 0)});
      cyc(60);
      want(5'h01, {4'h0, !k[0]});
      hst = 1'h1;
      cyc(1);
      hst = 1'h0;
      cyc(5);
      want(5'h01, {4'h0, 1'(k != 3)});
    end
    want(5'h06, 5'h00);
    pulse_a(6'h10);
    want(5'h06, 5'h00);
    st_done = 1'h1;
    pulse_a(6'h18);
    want(5'h06, 5'h00);
    pulse_a(6'h10);
    want(5'h06, 5'h06);
    for (j = 0; j < 6; j++) begin
      if (j != 4) begin
        pulse_a(6'(6'h01 << j));
        want(5'h06, 5'h00);
        pulse_a(6'h10);
        want(5'h06, 5'h06);
      end
    end
    int_f = 1'h1;
    cyc(3);
    want(5'h16, 5'h10);
    int_f = 1'h0;
    f_cmd = 1'h1;
    pulse_a(6'h10);
    want(5'h16, 5'h16);
    f_cmd = 1'h0;
    pa_f = 1'h1;
    cyc(3);
    want(5'h10, 5'h00);
    pb_f = 1'h1;
    cyc(3);
    want(5'h10, 5'h10);
    spin = dsc_pkg::DSC_SPIN_SPEED;
    cyc(4);
    want(5'h08, 5'h08);
    cmd = 1'h1;
    cyc(4);
    want(5'h08, 5'h00);
    spin = dsc_pkg::DSC_SPIN_STOP;
    cyc(4);
    want(5'h08, 5'h08);
    cmd = 1'h0;
    cyc(4);
    count(100);
    check(lit[4:0], 5'h14);
    spin = dsc_pkg::DSC_SPIN_RAMP;
    cyc(4);
    count(20);
    check(lit[4:0], 5'h0A);
    fmt = 1'h1;
    for (j = 0; j < 2; j++) begin
      cyc(4);
      prev = a_oe;
      cyl = 1'h1;
      cyc(1);
      cyl = 1'h0;
      cyc(3);
      check({4'h0, a_oe ^ prev}, 5'h01);
    end
    cyc(2);
    conclude();
  end
endmodule
